// *** logic/bafiu_consts.vh ***
// Opcode, flag position, reset value and cycle count constants of the branch and flag unit.
`ifndef BAFIU_CONSTS_VH
`define BAFIU_CONSTS_VH

// Flag positions inside the status flags register.
`define BAFIU_FLAG_C 0
`define BAFIU_FLAG_Z 1
`define BAFIU_FLAG_N 2
`define BAFIU_FLAG_V 3
`define BAFIU_FLAG_S 4
`define BAFIU_FLAG_H 5
`define BAFIU_FLAG_T 6
`define BAFIU_FLAG_I 7

// Reset value of the status flags register.
`define BAFIU_FLAGS_RST 8'h00

// Cycle counts: one for plain work, two for a taken branch.
`define BAFIU_CYC_ONE   2'h1
`define BAFIU_CYC_TAKEN 2'h2

// Skip instructions.
`define BAFIU_OP_SKIO_CLR  6'h00
`define BAFIU_OP_SKIO_SET  6'h01
`define BAFIU_OP_SKREG_CLR 6'h02
`define BAFIU_OP_SKREG_SET 6'h03

// Conditional relative branches.
`define BAFIU_OP_BR_IDX_SET 6'h04
`define BAFIU_OP_BR_IDX_CLR 6'h05
`define BAFIU_OP_BR_EQ      6'h08
`define BAFIU_OP_BR_NE      6'h09
`define BAFIU_OP_BR_CS      6'h0A
`define BAFIU_OP_BR_CC      6'h0B
`define BAFIU_OP_BR_SH      6'h0C
`define BAFIU_OP_BR_LO      6'h0D
`define BAFIU_OP_BR_MI      6'h0E
`define BAFIU_OP_BR_PL      6'h0F
`define BAFIU_OP_BR_GE      6'h10
`define BAFIU_OP_BR_LT      6'h11
`define BAFIU_OP_BR_HS      6'h12
`define BAFIU_OP_BR_HC      6'h13
`define BAFIU_OP_BR_TS      6'h14
`define BAFIU_OP_BR_TC      6'h15
`define BAFIU_OP_BR_VS      6'h16
`define BAFIU_OP_BR_VC      6'h17
`define BAFIU_OP_BR_IE      6'h18
`define BAFIU_OP_BR_ID      6'h19

// Shifts, rotates, bit transfer and interrupt enable on and off.
`define BAFIU_OP_SHIFT_UP    6'h20
`define BAFIU_OP_SHIFT_DOWN  6'h21
`define BAFIU_OP_ROT_UP      6'h22
`define BAFIU_OP_ROT_DOWN    6'h23
`define BAFIU_OP_ASHIFT_DOWN 6'h24
`define BAFIU_OP_BIT_STORE   6'h25
`define BAFIU_OP_BIT_LOAD    6'h26
`define BAFIU_OP_IRQ_ON      6'h27
`define BAFIU_OP_IRQ_OFF     6'h28

// Dedicated flag set and clear.
`define BAFIU_OP_SEC 6'h30
`define BAFIU_OP_CLC 6'h31
`define BAFIU_OP_SEN 6'h32
`define BAFIU_OP_CLN 6'h33
`define BAFIU_OP_SEZ 6'h34
`define BAFIU_OP_CLZ 6'h35
`define BAFIU_OP_SES 6'h36
`define BAFIU_OP_CLS 6'h37
`define BAFIU_OP_SEV 6'h38
`define BAFIU_OP_CLV 6'h39
`define BAFIU_OP_SET 6'h3A
`define BAFIU_OP_CLT 6'h3B
`define BAFIU_OP_SEH 6'h3C
`define BAFIU_OP_CLH 6'h3D

`endif

// *** logic/bafiu_shift.v ***
// Shift and rotate datapath with its zero, carry, negative and overflow results.
`include "bafiu_consts.vh"

module bafiu_shift (
    // Operation and operand.
    input  wire [5:0] op_i,
    input  wire [7:0] val_i,
    input  wire       carry_i,
    // Result and flags.
    output reg  [7:0] res_o,
    output reg        c_o,
    output wire       z_o,
    output wire       n_o,
    output wire       v_o
);

    // Each form moves one bit out to carry; unknown codes pass the value through.
    always @* begin
        res_o = val_i;
        c_o   = carry_i;
        case (op_i)
            `BAFIU_OP_SHIFT_UP: begin
                res_o = {val_i[6:0], 1'b0};
                c_o   = val_i[7];
            end
            `BAFIU_OP_SHIFT_DOWN: begin
                res_o = {1'b0, val_i[7:1]};
                c_o   = val_i[0];
            end
            `BAFIU_OP_ROT_UP: begin
                res_o = {val_i[6:0], carry_i};
                c_o   = val_i[7];
            end
            `BAFIU_OP_ROT_DOWN: begin
                res_o = {carry_i, val_i[7:1]};
                c_o   = val_i[0];
            end
            `BAFIU_OP_ASHIFT_DOWN: begin
                res_o = {val_i[7], val_i[7:1]};
                c_o   = val_i[0];
            end
            default: begin
                res_o = val_i;
                c_o   = carry_i;
            end
        endcase
    end

    // Overflow follows negative xor carry so signed tests stay consistent after a shift.
    assign z_o = (res_o == 8'h00);
    assign n_o = res_o[7];
    assign v_o = n_o ^ c_o;

endmodule // bafiu_shift

// *** logic/bafiu_core.v ***
// Execution unit for skips, flag branches, shifts, bit transfer and flag set and clear.
`include "bafiu_consts.vh"

// How it works
// - I/O skip when addressed bit is zero.
// - I/O skip when bit one, flags kept.
// - Indexed flag branch goes to PC+k+1.
// - Equal and not-equal follow zero flag.
// - Carry, lower and higher branches follow carry.
// - Minus and plus branches follow negative.
// - Signed branches follow negative xor overflow.
// - Half-carry branches follow half carry.
// - Transfer-bit branches follow T flag.
// - Overflow branches follow overflow flag.
// - Interrupt branches follow interrupt enable.
// - Logical shifts fill zero, update four flags.
// - Rotates pass through carry, one cycle.
// - Arithmetic shift right keeps sign bit.
// - Bit store copies register bit into T.
// - Bit load writes T into register bit.
// - Interrupt enable forced on or off.
// - Dedicated ops set or clear single flags.
// - Register skip tests chosen register bit.
module bafiu_core #(
    parameter PC_W = 16,
    parameter K_W  = 7
) (
    // Clock and reset.
    input  wire            clk_i,
    input  wire            resetn_i,
    // Instruction request.
    input  wire            exec_i,
    input  wire [5:0]      op_i,
    input  wire [2:0]      flag_sel_i,
    input  wire [K_W-1:0]  offset_i,
    input  wire [2:0]      bit_sel_i,
    input  wire [7:0]      reg_val_i,
    input  wire [7:0]      io_val_i,
    input  wire            next_two_i,
    output wire            ready_o,
    // External loads of program counter and flags.
    input  wire            pc_load_i,
    input  wire [PC_W-1:0] pc_load_val_i,
    input  wire            flags_load_i,
    input  wire [7:0]      flags_load_val_i,
    // Results.
    output wire            done_o,
    output wire [PC_W-1:0] pc_o,
    output wire [7:0]      flags_o,
    output wire [7:0]      rd_val_o,
    output wire            rd_we_o
);

    // Kinds of work that decide the program counter update.
    // Plain work always advances the counter by one word.
    localparam [1:0] KIND_PLAIN  = 2'h0;
    localparam [1:0] KIND_BRANCH = 2'h1;
    localparam [1:0] KIND_SKIP   = 2'h2;

    // Architectural state and its next values, then decode and datapath nets.
    reg  [PC_W-1:0] pc_q;
    reg  [PC_W-1:0] pc_d;
    reg  [7:0]      flags_q;
    reg  [7:0]      flags_d;
    reg  [7:0]      rd_val_q;
    reg  [7:0]      rd_val_d;
    reg             rd_we_q;
    reg             rd_we_d;
    reg  [1:0]      cnt_q;
    reg  [1:0]      cyc_d;
    reg             done_q;
    reg             cond;
    reg  [1:0]      kind;
    wire            accept;
    wire [7:0]      sh_res;
    wire            sh_c;
    wire            sh_z;
    wire            sh_n;
    wire            sh_v;
    wire [7:0]      bit_load_val;
    wire [PC_W-1:0] pc_inc;
    wire [PC_W-1:0] pc_rel;
    wire [PC_W-1:0] pc_skip;
    wire [1:0]      skip_words;

    // Flag aliases keep the condition table readable.
    // Positions come from the header, so the layout can move without touching logic.
    wire f_c = flags_q[`BAFIU_FLAG_C];
    wire f_z = flags_q[`BAFIU_FLAG_Z];
    wire f_n = flags_q[`BAFIU_FLAG_N];
    wire f_v = flags_q[`BAFIU_FLAG_V];
    wire f_h = flags_q[`BAFIU_FLAG_H];
    wire f_t = flags_q[`BAFIU_FLAG_T];
    wire f_i = flags_q[`BAFIU_FLAG_I];

    // The unit takes a new instruction only once the previous one has used its cycles.
    // ready_o is combinational so one-cycle work can follow back to back; a request
    // that meets ready_o low is not taken and must be held or repeated by the caller.
    assign ready_o = (cnt_q == 2'h0);
    assign accept  = exec_i & ready_o;

    // Shift and rotate datapath. It reads reg_val_i directly, so the operand only
    // has to stand at the accept edge; the unit keeps no copy of it.
    // Its flag outputs are ignored for every other opcode.
    bafiu_shift u_shift (
        .op_i    (op_i),
        .val_i   (reg_val_i),
        .carry_i (f_c),
        .res_o   (sh_res),
        .c_o     (sh_c),
        .z_o     (sh_z),
        .n_o     (sh_n),
        .v_o     (sh_v)
    );

    // Bit load replaces only the selected bit with T.
    // One comparator per bit avoids a write through a variable index.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bit_load
            assign bit_load_val[g] = (bit_sel_i == g) ? f_t : reg_val_i[g];
        end
    endgenerate

    // Program counter candidates; the offset is sign extended to the counter width.
    // All sums wrap at PC_W bits, as a program counter does at the top of memory.
    // The follower's length comes from next_two_i, since the unit never fetches it.
    assign pc_inc     = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
    assign pc_rel     = pc_inc + {{(PC_W-K_W){offset_i[K_W-1]}}, offset_i};
    assign skip_words = next_two_i ? 2'h2 : 2'h1;
    assign pc_skip    = pc_inc + {{(PC_W-2){1'b0}}, skip_words};

    // Condition and kind of the requested instruction.
    // Decoding runs every cycle but only matters while accept is high.
    // Undefined codes fall to the plain kind and act as a one-cycle no-op.
    always @* begin
        cond = 1'b0;
        kind = KIND_BRANCH;
        case (op_i)
            `BAFIU_OP_SKIO_CLR: begin
                cond = ~io_val_i[bit_sel_i];
                kind = KIND_SKIP;
            end
            `BAFIU_OP_SKIO_SET: begin
                cond = io_val_i[bit_sel_i];
                kind = KIND_SKIP;
            end
            `BAFIU_OP_SKREG_CLR: begin
                cond = ~reg_val_i[bit_sel_i];
                kind = KIND_SKIP;
            end
            `BAFIU_OP_SKREG_SET: begin
                cond = reg_val_i[bit_sel_i];
                kind = KIND_SKIP;
            end
            `BAFIU_OP_BR_IDX_SET: cond = flags_q[flag_sel_i];
            `BAFIU_OP_BR_IDX_CLR: cond = ~flags_q[flag_sel_i];
            `BAFIU_OP_BR_EQ:      cond = f_z;
            `BAFIU_OP_BR_NE:      cond = ~f_z;
            `BAFIU_OP_BR_CS:      cond = f_c;
            `BAFIU_OP_BR_LO:      cond = f_c;
            `BAFIU_OP_BR_CC:      cond = ~f_c;
            `BAFIU_OP_BR_SH:      cond = ~f_c;
            `BAFIU_OP_BR_MI:      cond = f_n;
            `BAFIU_OP_BR_PL:      cond = ~f_n;
            `BAFIU_OP_BR_GE:      cond = ~(f_n ^ f_v);
            `BAFIU_OP_BR_LT:      cond = f_n ^ f_v;
            `BAFIU_OP_BR_HS:      cond = f_h;
            `BAFIU_OP_BR_HC:      cond = ~f_h;
            `BAFIU_OP_BR_TS:      cond = f_t;
            `BAFIU_OP_BR_TC:      cond = ~f_t;
            `BAFIU_OP_BR_VS:      cond = f_v;
            `BAFIU_OP_BR_VC:      cond = ~f_v;
            `BAFIU_OP_BR_IE:      cond = f_i;
            `BAFIU_OP_BR_ID:      cond = ~f_i;
            default:              kind = KIND_PLAIN;
        endcase
    end

    // Next counter and cycle budget; branches and skips never touch the flags.
    // The budget never exceeds three, so the two-bit counter cannot wrap.
    always @* begin
        case (kind)
            KIND_BRANCH: begin
                pc_d  = cond ? pc_rel : pc_inc;
                cyc_d = cond ? `BAFIU_CYC_TAKEN : `BAFIU_CYC_ONE;
            end
            KIND_SKIP: begin
                pc_d  = cond ? pc_skip : pc_inc;
                cyc_d = cond ? (`BAFIU_CYC_ONE + skip_words) : `BAFIU_CYC_ONE;
            end
            default: begin
                pc_d  = pc_inc;
                cyc_d = `BAFIU_CYC_ONE;
            end
        endcase
    end

    // Flag and register write effects of the plain instructions, each one cycle.
    // Shifts leave the signed flag alone; only its own set and clear ops move it.
    // rd_val_d holds when nothing is written, so rd_val_o keeps the last result.
    always @* begin
        flags_d  = flags_q;
        rd_val_d = rd_val_q;
        rd_we_d  = 1'b0;
        case (op_i)
            `BAFIU_OP_SHIFT_UP,
            `BAFIU_OP_SHIFT_DOWN,
            `BAFIU_OP_ROT_UP,
            `BAFIU_OP_ROT_DOWN,
            `BAFIU_OP_ASHIFT_DOWN: begin
                rd_val_d                = sh_res;
                rd_we_d                 = 1'b1;
                flags_d[`BAFIU_FLAG_C]  = sh_c;
                flags_d[`BAFIU_FLAG_Z]  = sh_z;
                flags_d[`BAFIU_FLAG_N]  = sh_n;
                flags_d[`BAFIU_FLAG_V]  = sh_v;
            end
            `BAFIU_OP_BIT_STORE: flags_d[`BAFIU_FLAG_T] = reg_val_i[bit_sel_i];
            `BAFIU_OP_BIT_LOAD: begin
                rd_val_d = bit_load_val;
                rd_we_d  = 1'b1;
            end
            `BAFIU_OP_IRQ_ON:  flags_d[`BAFIU_FLAG_I] = 1'b1;
            `BAFIU_OP_IRQ_OFF: flags_d[`BAFIU_FLAG_I] = 1'b0;
            `BAFIU_OP_SEC: flags_d[`BAFIU_FLAG_C] = 1'b1;
            `BAFIU_OP_CLC: flags_d[`BAFIU_FLAG_C] = 1'b0;
            `BAFIU_OP_SEN: flags_d[`BAFIU_FLAG_N] = 1'b1;
            `BAFIU_OP_CLN: flags_d[`BAFIU_FLAG_N] = 1'b0;
            `BAFIU_OP_SEZ: flags_d[`BAFIU_FLAG_Z] = 1'b1;
            `BAFIU_OP_CLZ: flags_d[`BAFIU_FLAG_Z] = 1'b0;
            `BAFIU_OP_SES: flags_d[`BAFIU_FLAG_S] = 1'b1;
            `BAFIU_OP_CLS: flags_d[`BAFIU_FLAG_S] = 1'b0;
            `BAFIU_OP_SEV: flags_d[`BAFIU_FLAG_V] = 1'b1;
            `BAFIU_OP_CLV: flags_d[`BAFIU_FLAG_V] = 1'b0;
            `BAFIU_OP_SET: flags_d[`BAFIU_FLAG_T] = 1'b1;
            `BAFIU_OP_CLT: flags_d[`BAFIU_FLAG_T] = 1'b0;
            `BAFIU_OP_SEH: flags_d[`BAFIU_FLAG_H] = 1'b1;
            `BAFIU_OP_CLH: flags_d[`BAFIU_FLAG_H] = 1'b0;
            default: begin
                flags_d  = flags_q;
                rd_val_d = rd_val_q;
                rd_we_d  = 1'b0;
            end
        endcase
    end

    // Architectural state. An accepted instruction wins over an external load in the
    // same cycle, since the core must not retire two updates of one register at once.
    // A load in the busy cycles of a taken branch or skip still lands, which lets a
    // debugger patch state between instructions.
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_q     <= {PC_W{1'b0}};
            flags_q  <= `BAFIU_FLAGS_RST;
            rd_val_q <= 8'h00;
            rd_we_q  <= 1'b0;
        end else begin
            rd_we_q <= accept & rd_we_d;
            if (accept) begin
                pc_q     <= pc_d;
                flags_q  <= flags_d;
                rd_val_q <= rd_val_d;
            end else begin
                if (pc_load_i) begin
                    pc_q <= pc_load_val_i;
                end
                if (flags_load_i) begin
                    flags_q <= flags_load_val_i;
                end
            end
        end
    end

    // Cycle counter: holds off the next request for the extra cycles of taken work.
    // done_o rises in the cycle after the work, together with ready_o, so a caller that waits for it
    // finds pc_o and flags_o already settled.
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= 2'h0;
            done_q <= 1'b0;
        end else if (accept) begin
            cnt_q  <= cyc_d - `BAFIU_CYC_ONE;
            done_q <= (cyc_d == `BAFIU_CYC_ONE);
        end else if (cnt_q != 2'h0) begin
            cnt_q  <= cnt_q - 2'h1;
            done_q <= (cnt_q == 2'h1);
        end else begin
            done_q <= 1'b0;
        end
    end

    // Data outputs straight from flip-flops.
    // They cannot glitch, at the price of one cycle before a result shows.
    assign pc_o     = pc_q;
    assign flags_o  = flags_q;
    assign rd_val_o = rd_val_q;
    assign rd_we_o  = rd_we_q;
    assign done_o   = done_q;

endmodule // bafiu_core

// *** sim/bafiu_core_assertions.sv ***
// Assertions on the ports of the branch and flag unit.
`include "bafiu_consts.vh"

module bafiu_core_chk #(
    parameter PC_W = 16,
    parameter K_W  = 7
) (
    // Clock, reset and request.
    input wire            clk_i,
    input wire            resetn_i,
    input wire            exec_i,
    input wire [5:0]      op_i,
    input wire [K_W-1:0]  offset_i,
    input wire [2:0]      bit_sel_i,
    input wire [7:0]      reg_val_i,
    input wire [7:0]      io_val_i,
    input wire            next_two_i,
    // Results.
    input wire            ready_o,
    input wire            done_o,
    input wire [PC_W-1:0] pc_o,
    input wire [7:0]      flags_o,
    input wire [7:0]      rd_val_o,
    input wire            rd_we_o
);
    // Accept strobe and the sign-extended branch target seen in this cycle.
    wire            acc = exec_i && ready_o;
    wire [PC_W-1:0] tgt = pc_o + {{(PC_W-K_W){offset_i[K_W-1]}}, offset_i} + 1'b1;
    wire            nv  = flags_o[`BAFIU_FLAG_N] ^ flags_o[`BAFIU_FLAG_V];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    eq_taken_a: assert property (acc && op_i == `BAFIU_OP_BR_EQ && flags_o[`BAFIU_FLAG_Z]
        |=> pc_o == $past(tgt) && !done_o ##1 done_o) else $error("equal branch wrong");
    signed_lt_a: assert property (acc && op_i == `BAFIU_OP_BR_LT && nv
        |=> pc_o == $past(tgt)) else $error("signed less branch wrong");
    br_flags_a: assert property (acc && op_i == `BAFIU_OP_BR_IDX_SET
        |=> $stable(flags_o)) else $error("branch altered flags");
    io_skip_a: assert property (acc && op_i == `BAFIU_OP_SKIO_CLR && !io_val_i[bit_sel_i]
        |=> pc_o == $past(pc_o) + 2'h2 + $past(next_two_i) ##[1:2] done_o)
        else $error("io skip wrong");
    shift_down_a: assert property (acc && op_i == `BAFIU_OP_SHIFT_DOWN |=> rd_we_o
        && rd_val_o == $past(reg_val_i) >> 1) else $error("right shift wrong");
    rotate_down_a: assert property (acc && op_i == `BAFIU_OP_ROT_DOWN
        |=> rd_val_o == {$past(flags_o[`BAFIU_FLAG_C]), $past(reg_val_i[7:1])})
        else $error("rotate right wrong");
    bit_store_a: assert property (acc && op_i == `BAFIU_OP_BIT_STORE
        |=> flags_o[`BAFIU_FLAG_T] == $past(reg_val_i[bit_sel_i])) else $error("bit store wrong");
    busy_limit_a: assert property (!ready_o |-> ##[1:2] ready_o)
        else $error("busy too long");

    // Main scenarios: taken branch, two-word skip, shift write.
    cover property (acc ##1 !ready_o ##1 done_o);
    cover property (acc ##1 !ready_o ##1 !ready_o ##1 done_o);
    cover property (rd_we_o);
endmodule // bafiu_core_chk

bind bafiu_core bafiu_core_chk #(.PC_W(PC_W), .K_W(K_W)) i_bafiu_core_chk (
    .clk_i, .resetn_i, .exec_i, .op_i, .offset_i, .bit_sel_i, .reg_val_i, .io_val_i,
    .next_two_i, .ready_o, .done_o, .pc_o, .flags_o, .rd_val_o, .rd_we_o
);

// *** sim/bafiu_core_tb.sv ***
// Self-checking testbench for the branch and flag unit.
`include "bafiu_consts.vh"

module bafiu_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Inputs start defined; the offset stays at minus three, so taken branches go back.
    logic        clk_i = 1'b0, resetn_i = 1'b0, exec_i = 1'b0, next_two_i = 1'b0;
    logic        pc_load_i = 1'b0, flags_load_i = 1'b0;
    logic [5:0]  op_i = 6'h00;
    logic [6:0]  offset_i = 7'h7D;
    logic [2:0]  flag_sel_i = 3'h0, bit_sel_i = 3'h0;
    logic [7:0]  reg_val_i = 8'h00, io_val_i = 8'h00, flags_load_val_i = 8'h00;
    logic [15:0] pc_load_val_i = 16'h0000;
    wire         ready_o, done_o, rd_we_o;
    wire [15:0]  pc_o;
    wire [7:0]   flags_o, rd_val_o;
    int          fails = 0, checks_done = 0, cyc;

    bafiu_core #(.PC_W(16), .K_W(7)) i_bafiu_core (
        .clk_i, .resetn_i, .exec_i, .op_i, .flag_sel_i, .offset_i, .bit_sel_i, .reg_val_i,
        .io_val_i, .next_two_i, .ready_o, .pc_load_i, .pc_load_val_i, .flags_load_i,
        .flags_load_val_i, .done_o, .pc_o, .flags_o, .rd_val_o, .rd_we_o
    );

    // 200 MHz clock.
    initial forever #2.5 clk_i = ~clk_i;

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Loads pc 100 and flags, issues one instruction, counts cycles up to done.
    task automatic run(input logic [7:0] fl, input logic [5:0] op, input logic [7:0] rv,
                       input logic [2:0] b, input logic nt);
        @(posedge clk_i);
        pc_load_i        <= 1'b1;
        flags_load_i     <= 1'b1;
        pc_load_val_i    <= 16'h0064;
        flags_load_val_i <= fl;
        @(posedge clk_i);
        pc_load_i    <= 1'b0;
        flags_load_i <= 1'b0;
        exec_i       <= 1'b1;
        op_i         <= op;
        reg_val_i    <= rv;
        io_val_i     <= rv;
        bit_sel_i    <= b;
        flag_sel_i   <= b;
        next_two_i   <= nt;
        @(posedge clk_i);
        exec_i <= 1'b0;
        cyc = 1;
        #1;
        while (done_o !== 1'b1 && cyc < 5) begin
            @(posedge clk_i);
            #1;
            cyc++;
        end
    endtask

    // Branch condition worked out independently; undefined codes never branch.
    function automatic logic taken(input logic [5:0] op, input logic [7:0] f, input logic [2:0] s);
        case (op)
            `BAFIU_OP_BR_IDX_SET, `BAFIU_OP_BR_IDX_CLR: taken = f[s] ^ (op == `BAFIU_OP_BR_IDX_CLR);
            `BAFIU_OP_BR_EQ, `BAFIU_OP_BR_NE: taken = f[`BAFIU_FLAG_Z] ^ (op == `BAFIU_OP_BR_NE);
            `BAFIU_OP_BR_CS, `BAFIU_OP_BR_LO: taken = f[`BAFIU_FLAG_C];
            `BAFIU_OP_BR_CC, `BAFIU_OP_BR_SH: taken = !f[`BAFIU_FLAG_C];
            `BAFIU_OP_BR_MI, `BAFIU_OP_BR_PL: taken = f[`BAFIU_FLAG_N] ^ (op == `BAFIU_OP_BR_PL);
            `BAFIU_OP_BR_GE, `BAFIU_OP_BR_LT:
                taken = f[`BAFIU_FLAG_N] ^ f[`BAFIU_FLAG_V] ^ (op == `BAFIU_OP_BR_GE);
            `BAFIU_OP_BR_HS, `BAFIU_OP_BR_HC: taken = f[`BAFIU_FLAG_H] ^ (op == `BAFIU_OP_BR_HC);
            `BAFIU_OP_BR_TS, `BAFIU_OP_BR_TC: taken = f[`BAFIU_FLAG_T] ^ (op == `BAFIU_OP_BR_TC);
            `BAFIU_OP_BR_VS, `BAFIU_OP_BR_VC: taken = f[`BAFIU_FLAG_V] ^ (op == `BAFIU_OP_BR_VC);
            `BAFIU_OP_BR_IE, `BAFIU_OP_BR_ID: taken = f[`BAFIU_FLAG_I] ^ (op == `BAFIU_OP_BR_ID);
            default: taken = 1'b0;
        endcase
    endfunction

    // All branch codes against flag patterns, the index taken from the opcode's low bits.
    task automatic t_branches();
        logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'h01 << `BAFIU_FLAG_N, 8'h01 << `BAFIU_FLAG_V};
        logic       tk;
        for (int p = 0; p < 4; p++) begin
            for (int o = `BAFIU_OP_BR_IDX_SET; o <= `BAFIU_OP_BR_ID; o++) begin
                tk = taken(6'(o), pats[p], 3'(o));
                run(pats[p], 6'(o), 8'h00, 3'(o), 1'b0);
                chk("branch pc", tk ? 16'h0062 : 16'h0065, pc_o);
                chk("branch cycles", tk ? 16'h0002 : 16'h0001, 16'(cyc));
                chk("branch flags", 16'(pats[p]), 16'(flags_o));
            end
        end
    endtask

    // Skips on bit 5 holding either value, over one- and two-word followers.
    task automatic t_skips();
        logic sk;
        for (int o = `BAFIU_OP_SKIO_CLR; o <= `BAFIU_OP_SKREG_SET; o++) begin
            for (int i = 0; i < 4; i++) begin
                sk = (o == `BAFIU_OP_SKIO_SET || o == `BAFIU_OP_SKREG_SET) == i[0];
                run(8'hA5, 6'(o), i[0] ? 8'h20 : 8'hDF, 3'h5, i[1]);
                chk("skip pc", sk ? 16'h0066 + i[1] : 16'h0065, pc_o);
                chk("skip cycles", sk ? 16'h0002 + i[1] : 16'h0001, 16'(cyc));
                chk("skip flags", 16'h00A5, 16'(flags_o));
            end
        end
    endtask

    // Shifts and rotates with carry in clear and set; the upper four flags must survive.
    task automatic t_shifts();
        logic [7:0] vals [3] = '{8'h81, 8'h01, 8'h80};
        logic [8:0] r;
        logic [7:0] ef;
        for (int o = `BAFIU_OP_SHIFT_UP; o <= `BAFIU_OP_ASHIFT_DOWN; o++) begin
            for (int i = 0; i < 6; i++) begin
                ef = (i >= 3) ? 8'hF1 : 8'hF0;
                case (6'(o))
                    `BAFIU_OP_SHIFT_UP: r = {vals[i % 3], 1'b0};
                    `BAFIU_OP_SHIFT_DOWN: r = {vals[i % 3][0], 1'b0, vals[i % 3][7:1]};
                    `BAFIU_OP_ROT_UP: r = {vals[i % 3], ef[0]};
                    `BAFIU_OP_ROT_DOWN: r = {vals[i % 3][0], ef[0], vals[i % 3][7:1]};
                    default: r = {vals[i % 3][0], vals[i % 3][7], vals[i % 3][7:1]};
                endcase
                run(ef, 6'(o), vals[i % 3], 3'h0, 1'b0);
                ef[`BAFIU_FLAG_C] = r[8];
                ef[`BAFIU_FLAG_Z] = r[7:0] == 8'h00;
                ef[`BAFIU_FLAG_N] = r[7];
                ef[`BAFIU_FLAG_V] = r[7] ^ r[8];
                chk("shift result", 16'(r[7:0]), 16'(rd_val_o));
                chk("shift write", 16'h0001, 16'(rd_we_o));
                chk("shift flags", 16'(ef), 16'(flags_o));
            end
        end
    endtask

    // Bit store then bit load with T at both values; all other bits opposite.
    task automatic t_bits();
        for (int tv = 0; tv < 2; tv++) begin
            run(tv ? 8'h00 : 8'hFF, `BAFIU_OP_BIT_STORE, tv ? 8'h10 : 8'hEF, 3'h4, 1'b0);
            chk("store flags", tv ? 16'h0040 : 16'h00BF, 16'(flags_o));
            run(tv ? 8'h40 : 8'hBF, `BAFIU_OP_BIT_LOAD, tv ? 8'h00 : 8'hFF, 3'h4, 1'b0);
            chk("load result", tv ? 16'h0010 : 16'h00EF, 16'(rd_val_o));
            chk("load flags", tv ? 16'h0040 : 16'h00BF, 16'(flags_o));
        end
    endtask

    // Every dedicated set and clear, starting from the opposite of its effect.
    task automatic t_flags();
        int         pos [7] = '{`BAFIU_FLAG_C, `BAFIU_FLAG_N, `BAFIU_FLAG_Z, `BAFIU_FLAG_S,
                                `BAFIU_FLAG_V, `BAFIU_FLAG_T, `BAFIU_FLAG_H};
        logic [7:0] m;
        for (int i = 0; i < 16; i++) begin
            m = 8'h01 << (i < 14 ? pos[i / 2] : `BAFIU_FLAG_I);
            run(i[0] ? 8'hFF : 8'h00,
                i < 14 ? 6'(`BAFIU_OP_SEC + i) : 6'(`BAFIU_OP_IRQ_ON + i - 14), 8'h00, 3'h0, 1'b0);
            chk("flag op", {8'h00, i[0] ? ~m : m}, 16'(flags_o));
        end
    endtask

    // A taken branch refuses a request in its busy cycle, a load loses against an
    // accepted instruction, and one-cycle work then runs back to back.
    task automatic t_order();
        @(posedge clk_i);
        pc_load_i        <= 1'b1;
        flags_load_i     <= 1'b1;
        pc_load_val_i    <= 16'h0064;
        flags_load_val_i <= 8'h02;
        @(posedge clk_i);
        pc_load_i    <= 1'b0;
        flags_load_i <= 1'b0;
        exec_i       <= 1'b1;
        op_i         <= `BAFIU_OP_BR_EQ;
        @(posedge clk_i);
        op_i <= `BAFIU_OP_SEC;
        #1;
        chk("busy ready", 16'h0000, 16'(ready_o));
        @(posedge clk_i);
        pc_load_i     <= 1'b1;
        pc_load_val_i <= 16'h0010;
        #1;
        chk("refused flags", 16'h0002, 16'(flags_o));
        chk("taken done", 16'h0001, 16'(done_o));
        chk("free ready", 16'h0001, 16'(ready_o));
        @(posedge clk_i);
        op_i      <= `BAFIU_OP_SEN;
        pc_load_i <= 1'b0;
        #1;
        chk("load lost pc", 16'h0063, pc_o);
        chk("first flags", 16'h0003, 16'(flags_o));
        @(posedge clk_i);
        exec_i <= 1'b0;
        #1;
        chk("second flags", 16'h0007, 16'(flags_o));
        chk("second done", 16'h0001, 16'(done_o));
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Reset for eight cycles, check reset values, then the scenarios.
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("reset pc", 16'h0000, pc_o);
        chk("reset flags", 16'h0000, 16'(flags_o));
        t_branches();
        t_skips();
        t_shifts();
        t_bits();
        t_flags();
        t_order();
        finish_test();
    end

    // The scenarios need some 530 cycles; a hang is cut off well beyond that.
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule // bafiu_core_tb
